// *** logic/intc_regs.svh ***
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH
// Data-memory addresses of the flag and mode nibbles
`define ADDR_EDGE_MODE_A 4'h0
`define ADDR_EDGE_MODE_B 4'h1
`define ADDR_KEY_MODE 4'h2
`define ADDR_PRIORITY 4'h3
`define ADDR_REQ_LO 4'h4
`define ADDR_REQ_HI 4'h5
`define ADDR_REQ_TOP 4'h6
`define ADDR_EN_LO 4'h7
`define ADDR_EN_HI 4'h8
`define ADDR_EN_TOP 4'h9
// Reset values
`define MODE_RESET 4'h0
`define PRIORITY_RESET 4'h0
// Field positions
`define SAMPLE_SEL_BIT 3
`define MASTER_EN_BIT 3
`define KEY_MODE_BIT 3
// Edge select codes
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
`define EDGE_NONE 2'h3
// Divided sampling tick: fx/64
`define SAMPLE_DIV 6'h3F
// Source indices, fixed priority order 0 = highest
`define SRC_BT 4'h0
`define SRC_DUAL 4'h1
`define SRC_PIN_A 4'h2
`define SRC_PIN_B 4'h3
`define SRC_SERIAL 4'h4
`define SRC_TIMER 4'h5
`define SRC_PULSE 4'h6
`define SRC_CLOCK 4'h7
`define SRC_KEY 4'h8
`endif

// *** logic/intc_pkg.sv ***
package intc_pkg;
	// Internal event strobes
	typedef struct packed {
		logic interval_tick;
		logic serial_done;
		logic timer_match;
		logic pulse_match;
		logic clock_tick;
	} internal_events_t;
	// CPU side acknowledge
	typedef struct packed {
		logic accept;
		logic [2:0] vector;
	} accept_t;
	typedef enum logic [1:0] {
		ST_NORMAL = 2'h0,
		ST_LOW = 2'h1,
		ST_HIGH = 2'h2
	} status_t;
endpackage : intc_pkg

// *** logic/noise_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "intc_regs.svh"
// ****************************************
// Sampling noise eliminator
// ****************************************
module noise_filter (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	input wire logic i_slow,
	output logic o_level
);
	logic [5:0] div;
	logic tick;
	logic samp;

	// Prescaler for the divided sampling clock
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div <= 6'h00;
		end else begin
			div <= div + 6'h01;
		end
	end
	assign tick = i_slow ? (div == `SAMPLE_DIV) : 1'b1;

	// Level taken only after two equal samples in a row
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			samp <= 1'b0;
			o_level <= 1'b0;
		end else if (tick) begin
			samp <= i_pin;
			if (samp == i_pin) begin
				o_level <= i_pin;
			end
		end
	end
endmodule : noise_filter
`default_nettype wire

// *** logic/vectored_interrupt_control.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "intc_regs.svh"
// Behaviour
// - Flag sets on its event; cleared by hardware when its vector is accepted.
// - Set request with set enable raises that source's vectored request line.
// - The same vectored request also drives the standby wake-up.
// - Software-written request flag acts like a hardware event.
// - Reset clears all request and enable flags.
// - Flags reachable by single-bit and four-bit accesses, no bank setting.
// - Dual-edge pin sets its flag on both rising and falling edges.
// - Internal sources set their own request flags.
// - Interval timer and dual-edge pin share one vector.
// - With both shared sources enabled, acceptance leaves both flags.
// - First edge pin filtered; pulses under two samples discarded.
// - Bit 3 of first mode register picks CPU clock or fx/64 sampling.
// - Bits 0 and 1 of first mode register select its edge.
// - Second edge pin edge chosen by its own mode register.
// - First and second mode registers reset to zero, rising edge.
// - Sampled pin need not detect during standby.
// - Key mode register rising mode: key-rise pin rising edge sets key flag.
// - Key mode: falling edge sets flag only if other selected keys high.
// - Key mode register resets to zero, rising edge on key-rise pin.
// - Low three priority bits name the nesting high-order source.
// - Priority bit 3 is master enable; enable/disable instructions drive it.
// - Priority register resets to zero.
// - High-order source accepted in status 0 or 1, others only status 0.
// - Simultaneous requests: highest fixed priority accepted first.
module vectored_interrupt_control (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_edge_pin_a,
	input wire logic i_edge_pin_b,
	input wire logic i_key_rise_pin,
	input wire logic i_dual_edge_pin,
	input wire logic [7:0] i_key_scan_inputs,
	input wire intc_pkg::internal_events_t i_events,
	input wire logic i_standby,
	input wire logic [3:0] i_addr,
	input wire logic i_wr4,
	input wire logic [3:0] i_wdata,
	input wire logic i_bit_wr,
	input wire logic [1:0] i_bit_sel,
	input wire logic i_bit_val,
	input wire logic i_enable_instruction,
	input wire logic i_disable_instruction,
	input wire intc_pkg::accept_t i_accept,
	input wire intc_pkg::status_t i_status,
	output logic [3:0] o_rdata,
	output logic [6:1] o_vectored_request_line,
	output logic o_take,
	output logic [2:0] o_take_vector,
	output logic o_wakeup,
	output logic [8:0] o_request_flag
);
	logic [8:0] request_flag;
	logic [8:0] source_enable_flag;
	logic [3:0] first_edge_mode_reg;
	logic [3:0] second_edge_mode_reg;
	logic [3:0] key_edge_mode_reg;
	logic [3:0] priority_register;
	logic [1:0] sync_a, sync_b, sync_k, sync_d;
	logic [7:0] sync_kr1, sync_kr2;
	logic prev_a, prev_b, prev_k, prev_d;
	logic [7:0] prev_kr;
	logic filt_a;
	logic [8:0] hw_set;
	logic [8:0] wr_mask, wr_val;
	logic [8:0] ack_clr;
	logic [6:1] vrq;
	logic [2:0] pick;
	logic [7:0] key_sel;
	logic master_enable;
	logic sampling_clock_select;
	logic [1:0] edge_select_low_high;

	assign master_enable = priority_register[`MASTER_EN_BIT];
	assign sampling_clock_select = first_edge_mode_reg[`SAMPLE_SEL_BIT];
	assign edge_select_low_high = first_edge_mode_reg[1:0];

	// Edge detect by mode code
	function automatic logic edge_hit(input logic [1:0] mode, input logic prev,
		input logic cur);
		case (mode)
			`EDGE_RISE: edge_hit = !prev && cur;
			`EDGE_FALL: edge_hit = prev && !cur;
			`EDGE_BOTH: edge_hit = prev != cur;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// Key group decode: code n selects the top n+1 key inputs
	function automatic logic [7:0] key_group(input logic [2:0] code);
		case (code)
			3'h0: key_group = 8'h80;
			3'h1: key_group = 8'hC0;
			3'h2: key_group = 8'hE0;
			3'h3: key_group = 8'hF0;
			3'h4: key_group = 8'hF8;
			3'h5: key_group = 8'hFC;
			3'h6: key_group = 8'hFE;
			default: key_group = 8'hFF;
		endcase
	endfunction : key_group

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			sync_k <= 2'h0;
			sync_d <= 2'h0;
			sync_kr1 <= 8'hFF;
			sync_kr2 <= 8'hFF;
		end else begin
			sync_a <= {sync_a[0], i_edge_pin_a};
			sync_b <= {sync_b[0], i_edge_pin_b};
			sync_k <= {sync_k[0], i_key_rise_pin};
			sync_d <= {sync_d[0], i_dual_edge_pin};
			sync_kr1 <= i_key_scan_inputs;
			sync_kr2 <= sync_kr1;
		end
	end

	// Noise filter on the first edge pin
	noise_filter u_filter (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_pin(sync_a[1]),
		.i_slow(sampling_clock_select),
		.o_level(filt_a)
	);

	// Previous levels for edge detection
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
			prev_k <= 1'b0;
			prev_d <= 1'b0;
			prev_kr <= 8'hFF;
		end else begin
			prev_a <= filt_a;
			prev_b <= sync_b[1];
			prev_k <= sync_k[1];
			prev_d <= sync_d[1];
			prev_kr <= sync_kr2;
		end
	end

	// ****************************************
	// Set sources
	// ****************************************
	always_comb begin
		key_sel = key_group(key_edge_mode_reg[2:0]);
		hw_set = 9'h000;
		hw_set[`SRC_BT] = i_events.interval_tick;
		hw_set[`SRC_DUAL] = prev_d != sync_d[1];
		hw_set[`SRC_PIN_A] = !i_standby
			&& edge_hit(edge_select_low_high, prev_a, filt_a);
		hw_set[`SRC_PIN_B] = edge_hit(second_edge_mode_reg[1:0], prev_b,
			sync_b[1]);
		hw_set[`SRC_SERIAL] = i_events.serial_done;
		hw_set[`SRC_TIMER] = i_events.timer_match;
		hw_set[`SRC_PULSE] = i_events.pulse_match;
		hw_set[`SRC_CLOCK] = i_events.clock_tick;
		if (key_edge_mode_reg[`KEY_MODE_BIT]) begin
			// Falling edge counts only if every selected key was high before
			hw_set[`SRC_KEY] = ((prev_kr & key_sel) == key_sel)
				&& ((sync_kr2 & key_sel) != key_sel);
		end else begin
			hw_set[`SRC_KEY] = !prev_k && sync_k[1];
		end
	end

	// Register writes into flag nibbles, single-bit or four-bit
	always_comb begin
		logic [3:0] m;
		logic [3:0] v;
		m = i_wr4 ? 4'hF : (i_bit_wr ? (4'h1 << i_bit_sel) : 4'h0);
		v = i_wr4 ? i_wdata : {4{i_bit_val}};
		wr_mask = 9'h000;
		wr_val = 9'h000;
		case (i_addr)
			`ADDR_REQ_LO, `ADDR_EN_LO: begin
				wr_mask[3:0] = m;
				wr_val[3:0] = v;
			end
			`ADDR_REQ_HI, `ADDR_EN_HI: begin
				wr_mask[7:4] = m;
				wr_val[7:4] = v;
			end
			`ADDR_REQ_TOP, `ADDR_EN_TOP: begin
				wr_mask[8] = m[0];
				wr_val[8] = v[0];
			end
			default: begin
				wr_mask = 9'h000;
			end
		endcase
	end

	// Acceptance clear; shared vector with both enabled clears nothing
	always_comb begin
		ack_clr = 9'h000;
		if (i_accept.accept) begin
			case (i_accept.vector)
				3'h1: begin
					if (!(source_enable_flag[`SRC_BT] && source_enable_flag[`SRC_DUAL])) begin
						ack_clr[`SRC_BT] = source_enable_flag[`SRC_BT];
						ack_clr[`SRC_DUAL] = source_enable_flag[`SRC_DUAL];
					end
				end
				3'h2: ack_clr[`SRC_PIN_A] = 1'b1;
				3'h3: ack_clr[`SRC_PIN_B] = 1'b1;
				3'h4: ack_clr[`SRC_SERIAL] = 1'b1;
				3'h5: ack_clr[`SRC_TIMER] = 1'b1;
				3'h6: ack_clr[`SRC_PULSE] = 1'b1;
				default: ack_clr = 9'h000;
			endcase
		end
	end

	// ****************************************
	// Flags
	// ****************************************
	// Request flags: hardware set beats every clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			request_flag <= 9'h000;
		end else begin
			for (int i = 0; i < 9; i++) begin
				if (hw_set[i]) begin
					request_flag[i] <= 1'b1;
				end else if (wr_mask[i] && (i_addr == `ADDR_REQ_LO || i_addr == `ADDR_REQ_HI
					|| i_addr == `ADDR_REQ_TOP)) begin
					request_flag[i] <= wr_val[i];
				end else if (ack_clr[i]) begin
					request_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Enable flags
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			source_enable_flag <= 9'h000;
		end else if (i_addr == `ADDR_EN_LO || i_addr == `ADDR_EN_HI || i_addr == `ADDR_EN_TOP) begin
			source_enable_flag <= (source_enable_flag & ~wr_mask) | (wr_val & wr_mask);
		end
	end

	// Mode and priority registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_edge_mode_reg <= `MODE_RESET;
			second_edge_mode_reg <= `MODE_RESET;
			key_edge_mode_reg <= `MODE_RESET;
			priority_register <= `PRIORITY_RESET;
		end else begin
			if (i_wr4 && i_addr == `ADDR_EDGE_MODE_A) first_edge_mode_reg <= i_wdata;
			if (i_wr4 && i_addr == `ADDR_EDGE_MODE_B) second_edge_mode_reg <= i_wdata;
			if (i_wr4 && i_addr == `ADDR_KEY_MODE) key_edge_mode_reg <= i_wdata;
			if (i_wr4 && i_addr == `ADDR_PRIORITY) begin
				priority_register <= i_wdata;
			end else if (i_enable_instruction) begin
				priority_register[`MASTER_EN_BIT] <= 1'b1;
			end else if (i_disable_instruction) begin
				priority_register[`MASTER_EN_BIT] <= 1'b0;
			end
		end
	end

	// ****************************************
	// Vector requests and selection
	// ****************************************
	always_comb begin
		logic [8:0] act;
		act = request_flag & source_enable_flag;
		vrq[1] = act[`SRC_BT] | act[`SRC_DUAL];
		vrq[2] = act[`SRC_PIN_A];
		vrq[3] = act[`SRC_PIN_B];
		vrq[4] = act[`SRC_SERIAL];
		vrq[5] = act[`SRC_TIMER];
		vrq[6] = act[`SRC_PULSE];
		pick = 3'h0;
		// Lowest number wins; high-order source may nest in status 1
		for (int n = 6; n >= 1; n--) begin
			if (vrq[n] && master_enable && (i_status == intc_pkg::ST_NORMAL
				|| (i_status == intc_pkg::ST_LOW
				&& priority_register[2:0] == 3'(n)))) begin
				pick = 3'(n);
			end
		end
	end

	// Registered outputs
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_vectored_request_line <= 6'h00;
			o_take <= 1'b0;
			o_take_vector <= 3'h0;
			o_wakeup <= 1'b0;
			o_request_flag <= 9'h000;
		end else begin
			o_vectored_request_line <= vrq;
			o_take <= (pick != 3'h0) && !i_accept.accept;
			o_take_vector <= pick;
			o_wakeup <= |vrq | (request_flag[`SRC_KEY] & source_enable_flag[`SRC_KEY])
				| (request_flag[`SRC_CLOCK] & source_enable_flag[`SRC_CLOCK]);
			o_request_flag <= request_flag;
		end
	end

	// Read data
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 4'h0;
		end else begin
			case (i_addr)
				`ADDR_EDGE_MODE_A: o_rdata <= first_edge_mode_reg;
				`ADDR_EDGE_MODE_B: o_rdata <= second_edge_mode_reg;
				`ADDR_KEY_MODE: o_rdata <= key_edge_mode_reg;
				`ADDR_PRIORITY: o_rdata <= priority_register;
				`ADDR_REQ_LO: o_rdata <= request_flag[3:0];
				`ADDR_REQ_HI: o_rdata <= request_flag[7:4];
				`ADDR_REQ_TOP: o_rdata <= {3'h0, request_flag[8]};
				`ADDR_EN_LO: o_rdata <= source_enable_flag[3:0];
				`ADDR_EN_HI: o_rdata <= source_enable_flag[7:4];
				`ADDR_EN_TOP: o_rdata <= {3'h0, source_enable_flag[8]};
				default: o_rdata <= 4'h0;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	vrq_follows_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_vectored_request_line[4]
		== $past(request_flag[`SRC_SERIAL] && source_enable_flag[`SRC_SERIAL]))
		else $error("vectored request line wrong");
	wake_vrq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		|o_vectored_request_line |-> o_wakeup)
		else $error("wakeup missing");
	serial_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_events.serial_done |=> request_flag[`SRC_SERIAL])
		else $error("serial flag not set");
	dual_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(prev_d != sync_d[1]) |=> request_flag[`SRC_DUAL])
		else $error("dual edge missed");
	shared_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_accept.accept && i_accept.vector == 3'h1 && (&source_enable_flag[1:0])
		&& request_flag[`SRC_BT] && wr_mask == 9'h000 |=> request_flag[`SRC_BT])
		else $error("shared flag cleared");
	timer_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_accept.accept && i_accept.vector == 3'h5 && !hw_set[`SRC_TIMER]
		&& wr_mask == 9'h000 |=> !request_flag[`SRC_TIMER])
		else $error("timer flag not cleared");
	master_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!master_enable |=> !o_take)
		else $error("take with master off");
	status_two_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_status == intc_pkg::ST_HIGH |=> !o_take)
		else $error("take in status 2");
	order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		master_enable && i_status == intc_pkg::ST_NORMAL && vrq[1] |=> o_take_vector == 3'h1)
		else $error("priority order wrong");
endmodule : vectored_interrupt_control
`default_nettype wire

// *** test/cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// CPU core that accepts vectored requests
// ****************************************
module cpu_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_take,
	input wire logic [2:0] i_take_vector,
	input wire logic i_auto,
	input wire logic [3:0] i_delay,
	output intc_pkg::accept_t o_accept
);
	logic [3:0] wait_cnt;
	// Accept the offered vector after i_delay cycles, one-cycle pulse
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_accept <= '0;
			wait_cnt <= 4'h0;
		end else if (o_accept.accept) begin
			o_accept.accept <= 1'b0; // Never two accepts back to back
			wait_cnt <= 4'h0;
		end else if (i_auto && i_take) begin
			if (wait_cnt >= i_delay) begin
				o_accept <= {1'b1, i_take_vector};
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end else begin
			wait_cnt <= 4'h0;
		end
	end
endmodule : cpu_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Interrupt controller testbench
// ****************************************
module testbench;
	logic clk = 1'b0, rst_n = 1'b0;
	logic pin_a = 1'b0, pin_b = 1'b0, key_rise = 1'b0, dual = 1'b0, standby = 1'b0;
	logic [7:0] keys = 8'hFF;
	intc_pkg::internal_events_t ev = '0;
	logic [3:0] addr = 4'h0, wdata = 4'h0;
	logic wr4 = 1'b0, bit_wr = 1'b0, bit_val = 1'b0, ei = 1'b0, di = 1'b0, auto = 1'b0;
	logic [1:0] bit_sel = 2'h0;
	logic [3:0] delay = 4'h0;
	intc_pkg::accept_t acc;
	intc_pkg::status_t status = intc_pkg::ST_NORMAL;
	logic [3:0] rdata;
	logic [6:1] vrl;
	logic take, wakeup;
	logic [2:0] take_vec;
	logic [8:0] flags;
	int error_cnt = 0, samples_checked = 0;
	// 20 MHz clock
	always #25 clk = ~clk;
	vectored_interrupt_control i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_edge_pin_a(pin_a),
		.i_edge_pin_b(pin_b), .i_key_rise_pin(key_rise), .i_dual_edge_pin(dual),
		.i_key_scan_inputs(keys), .i_events(ev), .i_standby(standby), .i_addr(addr),
		.i_wr4(wr4), .i_wdata(wdata), .i_bit_wr(bit_wr), .i_bit_sel(bit_sel),
		.i_bit_val(bit_val), .i_enable_instruction(ei), .i_disable_instruction(di),
		.i_accept(acc), .i_status(status), .o_rdata(rdata), .o_vectored_request_line(vrl),
		.o_take(take), .o_take_vector(take_vec), .o_wakeup(wakeup), .o_request_flag(flags));
	cpu_model i_cpu (.i_clk(clk), .i_rst_n(rst_n), .i_take(take), .i_take_vector(take_vec),
		.i_auto(auto), .i_delay(delay), .o_accept(acc));
	// ****************************************
	// Access tasks
	// ****************************************
	task cyc(input int n = 1);
		repeat (n) @(posedge clk);
		#5;
	endtask : cyc
	task chk(input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [3:0] d);
		addr = a;
		wdata = d;
		wr4 = 1'b1;
		cyc();
		wr4 = 1'b0;
		cyc();
	endtask : wr
	task bset(input logic [3:0] a, input logic [1:0] b);
		addr = a;
		bit_sel = b;
		bit_val = 1'b1;
		bit_wr = 1'b1;
		cyc();
		bit_wr = 1'b0;
		cyc();
	endtask : bset
	task rd(input logic [3:0] a, input logic [3:0] e);
		addr = a;
		cyc();
		chk(9'(rdata), 9'(e));
	endtask : rd
	task pulse_ev(input intc_pkg::internal_events_t e);
		ev = e;
		cyc();
		ev = '0;
	endtask : pulse_ev
	task wait_acc(input logic [2:0] v);
		int i;
		// Step past any accept pulse left over from the previous call
		cyc();
		for (i = 0; i < 40 && acc.accept !== 1'b1; i++) cyc();
		if (acc.accept !== 1'b1) begin
			$display("[FAIL] %0t: no accept", $time);
			error_cnt++;
			summarize();
		end else begin
			chk(9'(acc.vector), 9'(v));
		end
	endtask : wait_acc
	task summarize();
		$display("Checked %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (12) @(posedge clk);
		#5 rst_n = 1'b1;
		cyc(4);
		chk(flags, 9'h000);
		for (int a = 0; a < 11; a++) rd(4'(a), 4'h0);
		wr(4'h3, 4'h5);
		rd(4'h3, 4'h5);
		ei = 1'b1;
		cyc();
		ei = 1'b0;
		rd(4'h3, 4'hD);
		wr(4'h7, 4'hF);
		wr(4'h8, 4'hF);
		// Serial completion raises vector 4
		pulse_ev(5'h08);
		cyc(3);
		chk(9'(vrl), 9'h008);
		chk({5'h0, wakeup, take_vec}, 9'h00C);
		// Three more pending, one set by software
		pulse_ev(5'h06);
		bset(4'h4, 2'h3);
		cyc(3);
		chk(flags, 9'h078);
		chk(9'(take_vec), 9'h003);
		status = intc_pkg::ST_LOW;
		cyc(3);
		chk(9'(take_vec), 9'h005);
		status = intc_pkg::ST_HIGH;
		cyc(3);
		chk(9'(take), 9'h000);
		status = intc_pkg::ST_NORMAL;
		di = 1'b1;
		cyc();
		di = 1'b0;
		cyc(3);
		chk(9'(take), 9'h000);
		ei = 1'b1;
		cyc();
		ei = 1'b0;
		auto = 1'b1;
		for (int v = 3; v < 7; v++) wait_acc(3'(v));
		auto = 1'b0;
		cyc(3);
		chk(flags, 9'h000);
		// Shared vector, both then one source enabled
		wr(4'h8, 4'h0);
		wr(4'h7, 4'h3);
		dual = 1'b1;
		cyc(6);
		chk(9'(flags[1]), 9'h001);
		wr(4'h4, 4'h0);
		dual = 1'b0;
		cyc(6);
		chk(9'(flags[1]), 9'h001);
		pulse_ev(5'h10);
		delay = 4'h3;
		auto = 1'b1;
		wait_acc(3'h1);
		auto = 1'b0;
		cyc(3);
		chk(9'(flags[1:0]), 9'h003);
		wr(4'h7, 4'h1);
		auto = 1'b1;
		wait_acc(3'h1);
		auto = 1'b0;
		cyc(3);
		chk(9'(flags[1:0]), 9'h002);
		// Pin A with divided sampling: 40-cycle pulse dropped, 200 kept
		wr(4'h7, 4'h0);
		wr(4'h0, 4'h8);
		cyc(70);
		wr(4'h4, 4'h0);
		pin_a = 1'b1;
		cyc(40);
		pin_a = 1'b0;
		cyc(140);
		chk(9'(flags[2]), 9'h000);
		pin_a = 1'b1;
		cyc(200);
		chk(9'(flags[2]), 9'h001);
		pin_a = 1'b0;
		cyc(140);
		// Falling edge, CPU clock sampling
		wr(4'h0, 4'h1);
		cyc(5);
		wr(4'h4, 4'h0);
		pin_a = 1'b1;
		cyc(6);
		chk(9'(flags[2]), 9'h000);
		pin_a = 1'b0;
		cyc(6);
		chk(9'(flags[2]), 9'h001);
		wr(4'h4, 4'h0);
		pin_a = 1'b1;
		cyc();
		pin_a = 1'b0;
		cyc(6);
		chk(9'(flags[2]), 9'h000);
		standby = 1'b1;
		pin_a = 1'b1;
		cyc(6);
		pin_a = 1'b0;
		cyc(6);
		chk(9'(flags[2]), 9'h000);
		standby = 1'b0;
		// Pin B on its own falling edge mode
		wr(4'h1, 4'h1);
		wr(4'h4, 4'h0);
		pin_b = 1'b1;
		cyc(6);
		chk(9'(flags[3]), 9'h000);
		pin_b = 1'b0;
		cyc(6);
		chk(9'(flags[3]), 9'h001);
		// Pin B on both edges, then with detection off
		wr(4'h1, 4'h2);
		wr(4'h4, 4'h0);
		pin_b = 1'b1;
		cyc(6);
		chk(9'(flags[3]), 9'h001);
		wr(4'h1, 4'h3);
		wr(4'h4, 4'h0);
		pin_b = 1'b0;
		cyc(6);
		chk(9'(flags[3]), 9'h000);
		// Clock timer tick sets its own flag
		pulse_ev(5'h01);
		cyc(3);
		chk(9'(flags[7]), 9'h001);
		// Key rise pin, then key mode on the top four keys
		key_rise = 1'b1;
		cyc(6);
		chk(9'(flags[8]), 9'h001);
		wr(4'h6, 4'h0);
		wr(4'h2, 4'hB);
		wr(4'h9, 4'h1);
		keys = 8'hEF;
		cyc(6);
		chk({7'h0, wakeup, flags[8]}, 9'h003);
		wr(4'h6, 4'h0);
		keys = 8'hCF;
		cyc(6);
		chk(9'(flags[8]), 9'h000);
		keys = 8'hFF;
		cyc(6);
		wr(4'h6, 4'h0);
		keys = 8'hF7;
		cyc(6);
		chk(9'(flags[8]), 9'h000);
		summarize();
	end
endmodule : testbench
`default_nettype wire
